// File: hw/err_defs.svh
// Offsets, bit positions, reset values and codes of the error detect block
`ifndef ERR_DEFS_SVH
`define ERR_DEFS_SVH

// Register byte offsets, one aligned 32-bit word each
`define AXI_AW          12
`define OFS_FLAGS       12'h000
`define OFS_MASK        12'h004
`define OFS_INHIBIT     12'h008
`define OFS_CAPSTAT     12'h00c

// Flag positions as stored (bit 0 of the printed layout is the msb)
`define B_REPEAT        31
`define B_TIMEOUT       23
`define B_ABORT         21
`define B_UNMAPPED      20
`define B_BAD_DATA      19
`define B_RETRY_NONCFG  18
`define B_INDIRECT_CFG  17
`define B_WINDOW_CFG    16
`define B_RETRY_THRESH  15
`define B_MSG_SIZE      14
`define B_IO_SIZE       13
`define B_CFG_SIZE      12
`define B_CFG_EP        11
`define B_IO_EP         10
`define B_WIN_CROSS     9
`define B_IO_HIGH       8

// Implemented bits of the flag/inhibit and the interrupt mask words
`define FLAG_MASK       32'h80bfff00
`define IE_MASK         32'h00bfff00
`define WORD_RST        32'h00000000

// Capture status layout
`define CAP_VALID_BIT   0
`define CAP_SRC_LSB     1
`define CAP_SRC_MSB     5
`define CAP_ORIG_BIT    6

// Completion status codes
`define CPL_SC          3'h0
`define CPL_UR          3'h1
`define CPL_CRS         3'h2
`define CPL_CA          3'h4

// Size limit for message, I/O and configuration requests
`define MAX_BYTES       13'h0004

// AXI responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// File: hw/err_pkg.sv
// Types shared by the error detect block and its environment
`include "err_defs.svh"
package err_pkg;

  // Kind of an outbound request
  typedef enum logic [1:0] {OB_MEM, OB_IO, OB_CFG, OB_MSG} ob_kind_t;

  // Detection strobes from the controller core, one-cycle pulses
  typedef struct packed {
    logic        cpl_valid;      // Completion received
    logic        cpl_has_data;   // It carries data
    logic [2:0]  cpl_status;     // Its status code
    logic        cpl_is_cfg;     // It answers a configuration cycle
    logic        inb_nomap;      // Inbound request hit no window
    logic        cfg_indirect_bad; // Illegal access via address/data pair
    logic        cfg_window_bad; // Illegal access via translation window
    logic        ob_valid;       // Outbound request presented
    ob_kind_t    ob_kind;
    logic [12:0] ob_len;         // Length in bytes
    logic [1:0]  ob_addr_lo;     // Low address bits
    logic        ob_via_window;  // Went through a translation window
    logic        ob_win_cross;   // Hit a window but runs past its end
    logic        ob_xlat_high;   // Translated address above 4 Gbyte
    logic        np_sent;        // Non-posted request left for the link
    logic        np_done;        // Its completion came back
  } ev_t;

  // Captured details of an error
  typedef struct packed {
    logic [4:0] source_id;
    logic       from_indirect;
  } cap_t;

  // AXI4-Lite master to slave
  typedef struct packed {
    logic [`AXI_AW-1:0] awaddr;
    logic               awvalid;
    logic [31:0]        wdata;
    logic [3:0]         wstrb;
    logic               wvalid;
    logic               bready;
    logic [`AXI_AW-1:0] araddr;
    logic               arvalid;
    logic               rready;
  } axi_req_t;

  // AXI4-Lite slave to master
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } axi_rsp_t;

endpackage

// File: hw/pcie_error_detect_irq.sv
// Error detect flags, interrupt mask, set inhibit and first-error capture
//
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "err_defs.svh"

module pcie_error_detect_irq #(
  parameter int unsigned CPL_TIMEOUT_CYCLES = 50000,
  parameter int unsigned CRS_RETRY_LIMIT    = 8
) (
  // Clock, reset, enable
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire logic              ce,
  // Register bus
  input  wire err_pkg::axi_req_t axi_req,
  output err_pkg::axi_rsp_t      axi_rsp,
  // Detection strobes and mode
  input  wire err_pkg::ev_t      ev,
  input  wire logic              root_complex_mode,
  input  wire err_pkg::cap_t     cap_in,
  // Answers to the core
  output logic                   err_irq,
  output logic                   timeout_err_resp,
  output logic                   crs_err_resp,
  output logic                   ur_cpl
);

  localparam int unsigned TO_W  = $clog2(CPL_TIMEOUT_CYCLES + 1);
  localparam int unsigned CRS_W = $clog2(CRS_RETRY_LIMIT + 1);
  localparam logic [TO_W-1:0]  TO_LAST  = TO_W'(CPL_TIMEOUT_CYCLES - 1);
  localparam logic [CRS_W-1:0] CRS_LAST = CRS_W'(CRS_RETRY_LIMIT - 1);

  // Expand byte strobes into a bit mask
  function automatic logic [31:0] strb_bits(input logic [3:0] strb);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

  // True when a request is longer than a word or crosses a word boundary
  function automatic logic bad_size(input logic [1:0]  lo,
                                    input logic [12:0] len);
    logic [13:0] span;
    span = {12'h000, lo} + {1'b0, len};
    return (len > `MAX_BYTES) || (span > {1'b0, `MAX_BYTES});
  endfunction

  // Word index of an address
  function automatic logic [`AXI_AW-3:0] word(input logic [`AXI_AW-1:0] a);
    return a[`AXI_AW-1:2];
  endfunction

  // ---------------- Bus slave state ----------------
  logic [`AXI_AW-1:0] awaddr_q, awaddr_d;
  logic [31:0]        wdata_q, wdata_d;
  logic [3:0]         wstrb_q, wstrb_d;
  logic               aw_full_q, aw_full_d;
  logic               w_full_q, w_full_d;
  err_pkg::axi_rsp_t  rsp_q, rsp_d;

  // ---------------- Register state ----------------
  logic [31:0]   flags_q, flags_d;
  logic [31:0]   mask_q, mask_d;
  logic [31:0]   inhibit_q, inhibit_d;
  logic          cap_valid_q, cap_valid_d;
  err_pkg::cap_t cap_q, cap_d;
  logic          irq_q, irq_d;
  logic          ur_q, ur_d;

  // ---------------- Timer and retry state ----------------
  logic             to_busy_q, to_busy_d;
  logic [TO_W-1:0]  to_cnt_q, to_cnt_d;
  logic             to_resp_q, to_resp_d;
  logic [CRS_W-1:0] crs_cnt_q, crs_cnt_d;
  logic             crs_resp_q, crs_resp_d;

  // Decoded strobes shared between processes
  logic        do_wr;
  logic [31:0] wr_bits;
  logic [31:0] rd_word;
  logic        rd_hit;
  logic        wr_hit;
  logic        to_expire;
  logic        crs_thresh;
  logic [31:0] det;

  // Write fires once both halves are held and no response is pending
  assign do_wr   = aw_full_q && w_full_q && !rsp_q.bvalid;
  assign wr_bits = wdata_q & strb_bits(wstrb_q);

  // Write address decode
  always_comb begin
    unique case (word(awaddr_q))
      word(`OFS_FLAGS), word(`OFS_MASK),
      word(`OFS_INHIBIT), word(`OFS_CAPSTAT): wr_hit = 1'b1;
      default:                               wr_hit = 1'b0;
    endcase
  end

  // Read mux; reserved bits come back as zero
  always_comb begin
    rd_word = '0;
    rd_hit  = 1'b1;
    unique case (word(axi_req.araddr))
      word(`OFS_FLAGS):   rd_word = flags_q & `FLAG_MASK;
      word(`OFS_MASK):    rd_word = mask_q & `IE_MASK;
      word(`OFS_INHIBIT): rd_word = inhibit_q & `FLAG_MASK;
      word(`OFS_CAPSTAT): begin
        rd_word[`CAP_VALID_BIT]                = cap_valid_q;
        rd_word[`CAP_SRC_MSB:`CAP_SRC_LSB]     = cap_q.source_id;
        rd_word[`CAP_ORIG_BIT]                 = cap_q.from_indirect;
      end
      default:            rd_hit  = 1'b0;
    endcase
  end

  // Bus channel handshakes; address and data are taken in either order
  always_comb begin
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    aw_full_d = aw_full_q;
    w_full_d  = w_full_q;
    rsp_d     = rsp_q;
    if (axi_req.awvalid && rsp_q.awready) begin
      awaddr_d  = axi_req.awaddr;
      aw_full_d = 1'b1;
    end
    if (axi_req.wvalid && rsp_q.wready) begin
      wdata_d  = axi_req.wdata;
      wstrb_d  = axi_req.wstrb;
      w_full_d = 1'b1;
    end
    if (do_wr) begin
      aw_full_d   = 1'b0;
      w_full_d    = 1'b0;
      rsp_d.bvalid = 1'b1;
      rsp_d.bresp  = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rsp_q.bvalid && axi_req.bready) begin
      rsp_d.bvalid = 1'b0;
    end
    // One write at a time: no new halves until the response is taken
    rsp_d.awready = !aw_full_d && !rsp_d.bvalid;
    rsp_d.wready  = !w_full_d && !rsp_d.bvalid;
    // Read answers in the cycle after the address is taken
    if (axi_req.arvalid && rsp_q.arready) begin
      rsp_d.rvalid = 1'b1;
      rsp_d.rdata  = rd_word;
      rsp_d.rresp  = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rsp_q.rvalid && axi_req.rready) begin
      rsp_d.rvalid = 1'b0;
    end
    rsp_d.arready = !rsp_d.rvalid;
  end

  // Bus slave registers
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      rsp_q     <= '0;
    end else if (ce) begin
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      rsp_q     <= rsp_d;
    end
  end

  // Completion timer, armed only once the request went out on the link
  always_comb begin
    to_busy_d = to_busy_q;
    to_cnt_d  = to_cnt_q;
    to_expire = 1'b0;
    if (ev.np_sent) begin
      to_busy_d = 1'b1;
      to_cnt_d  = '0;
    end else if (to_busy_q && ev.np_done) begin
      to_busy_d = 1'b0;
    end else if (to_busy_q) begin
      if (to_cnt_q == TO_LAST) begin
        to_expire = 1'b1;
        to_busy_d = 1'b0;
      end else begin
        to_cnt_d = to_cnt_q + TO_W'(1);
      end
    end
    to_resp_d = to_expire;
  end

  // Retry counter for configuration requests answered with CRS
  always_comb begin
    crs_cnt_d  = crs_cnt_q;
    crs_thresh = 1'b0;
    if (ev.cpl_valid && ev.cpl_is_cfg) begin
      if (ev.cpl_status == `CPL_CRS) begin
        if (crs_cnt_q == CRS_LAST) begin
          crs_thresh = 1'b1;
          crs_cnt_d  = '0;
        end else begin
          crs_cnt_d = crs_cnt_q + CRS_W'(1);
        end
      end else begin
        crs_cnt_d = '0;
      end
    end
    crs_resp_d = crs_thresh;
  end

  // Timer and retry registers
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      to_busy_q  <= 1'b0;
      to_cnt_q   <= '0;
      to_resp_q  <= 1'b0;
      crs_cnt_q  <= '0;
      crs_resp_q <= 1'b0;
    end else if (ce) begin
      to_busy_q  <= to_busy_d;
      to_cnt_q   <= to_cnt_d;
      to_resp_q  <= to_resp_d;
      crs_cnt_q  <= crs_cnt_d;
      crs_resp_q <= crs_resp_d;
    end
  end

  // Raw detections, before any inhibit is applied
  always_comb begin
    logic ob_sz;
    ob_sz = bad_size(ev.ob_addr_lo, ev.ob_len);
    det   = '0;
    det[`B_TIMEOUT]      = to_expire;
    det[`B_ABORT]        = ev.cpl_valid && (ev.cpl_status == `CPL_CA);
    det[`B_UNMAPPED]     = ev.inb_nomap && root_complex_mode;
    det[`B_BAD_DATA]     = ev.cpl_valid && ev.cpl_has_data &&
                           ((ev.cpl_status == `CPL_UR) ||
                            (ev.cpl_status == `CPL_CA) ||
                            (ev.cpl_status == `CPL_CRS));
    det[`B_RETRY_NONCFG] = ev.cpl_valid && !ev.cpl_is_cfg &&
                           (ev.cpl_status == `CPL_CRS);
    det[`B_INDIRECT_CFG] = ev.cfg_indirect_bad;
    det[`B_WINDOW_CFG]   = ev.cfg_window_bad;
    det[`B_RETRY_THRESH] = crs_thresh;
    det[`B_MSG_SIZE]     = ev.ob_valid && (ev.ob_kind == err_pkg::OB_MSG) && ob_sz;
    det[`B_IO_SIZE]      = ev.ob_valid && (ev.ob_kind == err_pkg::OB_IO) && ob_sz;
    det[`B_CFG_SIZE]     = ev.ob_valid && (ev.ob_kind == err_pkg::OB_CFG) && ob_sz;
    det[`B_CFG_EP]       = ev.ob_valid && !root_complex_mode &&
                           (ev.ob_kind == err_pkg::OB_CFG) && ev.ob_via_window;
    det[`B_IO_EP]        = ev.ob_valid && !root_complex_mode &&
                           (ev.ob_kind == err_pkg::OB_IO);
    det[`B_WIN_CROSS]    = ev.ob_valid && ev.ob_win_cross;
    det[`B_IO_HIGH]      = ev.ob_valid && (ev.ob_kind == err_pkg::OB_IO) &&
                           ev.ob_xlat_high;
  end

  // Flag, mask, inhibit and capture next values
  always_comb begin
    logic [31:0] clr;
    logic [31:0] set;
    logic        repeat_hit;
    logic        cap_clr;
    clr        = '0;
    set        = '0;
    repeat_hit = 1'b0;
    cap_clr    = 1'b0;
    mask_d     = mask_q;
    inhibit_d  = inhibit_q;
    cap_d      = cap_q;
    if (do_wr) begin
      unique case (word(awaddr_q))
        word(`OFS_FLAGS):   clr = wr_bits & `FLAG_MASK;
        word(`OFS_MASK):    mask_d = ((mask_q & ~strb_bits(wstrb_q)) | wr_bits)
                                     & `IE_MASK;
        word(`OFS_INHIBIT): inhibit_d = ((inhibit_q & ~strb_bits(wstrb_q)) | wr_bits)
                                        & `FLAG_MASK;
        word(`OFS_CAPSTAT): cap_clr = wr_bits[`CAP_VALID_BIT];
        default:            clr = '0;
      endcase
    end
    set = det & ~inhibit_q & `FLAG_MASK;
    repeat_hit = |(det & flags_q & `FLAG_MASK);
    set[`B_REPEAT] = repeat_hit && !inhibit_q[`B_REPEAT];
    flags_d = ((flags_q & ~clr) | set) & `FLAG_MASK;
    // capture first error only
    // A repeat on its own never triggers a capture
    if ((|(det & ~inhibit_q & `FLAG_MASK)) && (!cap_valid_q || cap_clr)) begin
      cap_d       = cap_in;
      cap_valid_d = 1'b1;
    end else begin
      cap_valid_d = cap_valid_q && !cap_clr;
    end
    irq_d = |(flags_d & mask_d & `IE_MASK);
    ur_d  = ev.inb_nomap;
  end

  // Register file and answer flops
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      flags_q     <= `WORD_RST;
      mask_q      <= `WORD_RST;
      inhibit_q   <= `WORD_RST;
      cap_valid_q <= 1'b0;
      cap_q       <= '0;
      irq_q       <= 1'b0;
      ur_q        <= 1'b0;
    end else if (ce) begin
      flags_q     <= flags_d;
      mask_q      <= mask_d;
      inhibit_q   <= inhibit_d;
      cap_valid_q <= cap_valid_d;
      cap_q       <= cap_d;
      irq_q       <= irq_d;
      ur_q        <= ur_d;
    end
  end

  // Outputs taken straight from flops
  assign axi_rsp          = rsp_q;
  assign err_irq          = irq_q;
  assign timeout_err_resp = to_resp_q;
  assign crs_err_resp     = crs_resp_q;
  assign ur_cpl           = ur_q;

endmodule // pcie_error_detect_irq

// File: tb/err_detect_monitor.sv
// Port-level checker for the error detect block
`timescale 1ns/10ps
`include "err_defs.svh"

module err_detect_monitor #(
  parameter int unsigned CPL_TIMEOUT_CYCLES = 50000
) (
  // Clock and reset
  input wire logic              ref_clk,
  input wire logic              resetn,
  // Register bus
  input wire err_pkg::axi_req_t axi_req,
  input wire err_pkg::axi_rsp_t axi_rsp,
  // Strobes and answers
  input wire err_pkg::ev_t      ev,
  input wire logic              timeout_err_resp,
  input wire logic              crs_err_resp,
  input wire logic              ur_cpl
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  logic        armed_q;
  logic        armed_d;
  logic [31:0] age_q;
  logic [31:0] age_d;

  // Age of the tracked request; a resend restarts it
  always_comb begin
    armed_d = armed_q;
    age_d   = age_q + 32'h1;
    if (ev.np_done || timeout_err_resp) armed_d = 1'b0;
    if (ev.np_sent) begin
      armed_d = 1'b1;
      age_d   = 32'h0;
    end
  end

  // Register the age tracker
  always_ff @(posedge ref_clk) begin
    armed_q <= resetn ? armed_d : 1'b0;
    age_q   <= resetn ? age_d : 32'h0;
  end

  sequence wr_taken;
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  endsequence
  sequence crs_cfg;
    ev.cpl_valid && ev.cpl_status == `CPL_CRS && ev.cpl_is_cfg;
  endsequence

  a_ur_answer: assert property (ev.inb_nomap |=> ur_cpl)
    else $error("ur_cpl missing");
  a_crs_cause: assert property (crs_err_resp |-> $past(ev.cpl_valid && ev.cpl_is_cfg))
    else $error("crs_err_resp without retry completion");
  a_crs_seen: assert property (crs_err_resp |-> ##0 1'b1 ##0 $past(ev.cpl_status) == `CPL_CRS)
    else $error("crs_err_resp after a non retry completion");
  a_timeout_window: assert property (timeout_err_resp |->
    armed_q && age_q + 2 >= CPL_TIMEOUT_CYCLES && age_q <= CPL_TIMEOUT_CYCLES + 1)
    else $error("timeout answer at wrong time");
  a_timeout_late: assert property (armed_q |-> age_q <= CPL_TIMEOUT_CYCLES + 1)
    else $error("timeout answer missing");
  a_write_answer: assert property (wr_taken |=> !axi_rsp.bvalid ##1 axi_rsp.bvalid)
    else $error("write response timing");
  a_read_answer: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("read data timing");
  a_resp_hold: assert property (axi_rsp.bvalid && !axi_req.bready |=>
    axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write response dropped");
  a_busy_refuse: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
    else $error("write taken while answering");
endmodule // err_detect_monitor

bind pcie_error_detect_irq err_detect_monitor #(.CPL_TIMEOUT_CYCLES(CPL_TIMEOUT_CYCLES)) u_mon (
  .ref_clk(ref_clk), .resetn(resetn), .axi_req(axi_req), .axi_rsp(axi_rsp), .ev(ev),
  .timeout_err_resp(timeout_err_resp), .crs_err_resp(crs_err_resp), .ur_cpl(ur_cpl));

// File: tb/pcie_core_model.sv
// Controller core model that raises detection strobes toward the block
`timescale 1ns/10ps

module pcie_core_model (
  // Clock
  input  wire logic   ref_clk,
  // Strobes to the block
  output err_pkg::ev_t ev
);
  initial ev = '0;

  // One-cycle strobe launched just after an edge
  task automatic fire(input err_pkg::ev_t e);
    @(posedge ref_clk);
    ev <= e;
    @(posedge ref_clk);
    ev <= '0;
  endtask

  // timer starts once sent
  // Non-posted request; the completion comes after a delay, or never
  task automatic np_req(input int dly, input bit answer);
    err_pkg::ev_t e;
    e = '0;
    e.np_sent = 1'b1;
    fire(e);
    repeat (dly) @(posedge ref_clk);
    if (answer) begin
      e = '0;
      e.np_done = 1'b1;
      fire(e);
    end
  endtask
endmodule // pcie_core_model

// File: tb/tb.sv
// Self-checking bench for the error detect block
`timescale 1ns/10ps
`include "err_defs.svh"

module tb;
  localparam int unsigned TMO = 16;
  logic              ref_clk;
  logic              resetn;
  logic              rc_mode;
  logic              ce;
  logic              irq;
  logic              to_resp;
  logic              crs_resp;
  logic              ur;
  logic [1:0]        rs;
  int                fails;
  int                n_tests;
  int                t;
  err_pkg::axi_req_t req;
  err_pkg::axi_rsp_t rsp;
  err_pkg::ev_t      ev;
  err_pkg::cap_t     cap;
  int unsigned       bits [14] = '{21, 19, 18, 20, 17, 16, 14, 13, 12, 9, 8, 11, 10, 0};

  // Short counts keep the timeout and retry runs brief
  pcie_error_detect_irq #(.CPL_TIMEOUT_CYCLES(TMO), .CRS_RETRY_LIMIT(2)) dut (
    .ref_clk(ref_clk), .resetn(resetn), .ce(ce), .axi_req(req), .axi_rsp(rsp), .ev(ev),
    .root_complex_mode(rc_mode), .cap_in(cap), .err_irq(irq), .timeout_err_resp(to_resp),
    .crs_err_resp(crs_resp), .ur_cpl(ur));
  pcie_core_model core (.ref_clk(ref_clk), .ev(ev));

  // 200 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] got);
    n_tests++;
    if (got !== x) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, x, got);
    end
  endtask

  // Write; bready comes late so the response must stand
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    @(posedge ref_clk);
    req <= '{awaddr: a, awvalid: 1'b1, wdata: d, wstrb: s, wvalid: 1'b1, default: '0};
    do begin
      @(posedge ref_clk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    req.bready <= 1'b1;
    @(posedge ref_clk);
    rs = rsp.bresp;
    req.bready <= 1'b0;
  endtask

  // Read and compare data and response
  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] x,
                      input logic [1:0] r = `RESP_OKAY);
    @(posedge ref_clk);
    req <= '{araddr: a, arvalid: 1'b1, rready: 1'b1, default: '0};
    do begin
      @(posedge ref_clk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    req.rready <= 1'b0;
    chk(nm, x, rsp.rdata);
    chk(nm, {30'h0, r}, {30'h0, rsp.rresp});
  endtask

  // Table of detectable conditions, one per index
  function automatic err_pkg::ev_t ev_of(input int i);
    err_pkg::ev_t e;
    e = '0;
    e.cpl_valid = i < 3 || i > 13;
    e.cpl_has_data = i == 1;
    e.cpl_is_cfg = i == 1 || i > 13;
    e.ob_valid = i > 5 && i < 13;
    e.ob_len = (i == 6) ? 13'h5 : (i == 8) ? 13'h8 : 13'h4;
    e.ob_addr_lo = (i == 7) ? 2'h3 : 2'h0;
    e.ob_via_window = i == 11;
    e.ob_win_cross = i == 9;
    e.ob_xlat_high = i == 10;
    e.inb_nomap = i == 3 || i == 13;
    e.cfg_indirect_bad = i == 4;
    e.cfg_window_bad = i == 5;
    case (i)
      0: e.cpl_status = `CPL_CA;
      1: e.cpl_status = `CPL_UR;
      2, 14: e.cpl_status = `CPL_CRS;
      6: e.ob_kind = err_pkg::OB_MSG;
      7, 10, 12: e.ob_kind = err_pkg::OB_IO;
      8, 11: e.ob_kind = err_pkg::OB_CFG;
      default: e.ob_kind = err_pkg::OB_MEM;
    endcase
    return e;
  endfunction

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    end_of_test();
  end

  // Main sequence
  initial begin
    req = '0;
    rc_mode = 1'b1;
    ce = 1'b1;
    cap = '0;
    resetn = 1'b0;
    fails = 0;
    n_tests = 0;
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    rchk("flags", `OFS_FLAGS, 32'h0);
    rchk("mask", `OFS_MASK, 32'h0);
    rchk("unmapped", 12'h010, 32'h0, `RESP_SLVERR);
    wr(12'h010, 32'hffffffff);
    chk("unmapped bresp", {30'h0, `RESP_SLVERR}, {30'h0, rs});
    wr(`OFS_MASK, 32'hffffffff);
    rchk("mask", `OFS_MASK, `IE_MASK);
    $display("Test registers done");
    // Each condition sets its own flag, save an unmapped access outside root complex mode; unmasked it raises the interrupt
    for (int i = 0; i < 14; i++) begin
      wr(`OFS_FLAGS, 32'hffffffff);
      @(posedge ref_clk) rc_mode <= (i < 11);
      core.fire(ev_of(i));
      // The unsupported-request answer pulses in both modes, one cycle later
      @(posedge ref_clk) chk("ur", {31'h0, i == 3 || i == 13}, {31'h0, ur});
      rchk("flag", `OFS_FLAGS, (i == 13) ? 32'h0 : 32'h1 << bits[i]);
      chk("irq", {31'h0, i != 13}, {31'h0, irq});
    end
    $display("Test conditions done");
    // Repeat flag, byte-lane clearing, then inhibit
    @(posedge ref_clk) rc_mode <= 1'b1;
    wr(`OFS_FLAGS, 32'hffffffff);
    wr(`OFS_MASK, 32'h00000100);
    repeat (2) core.fire(ev_of(0));
    rchk("repeat", `OFS_FLAGS, 32'h80200000);
    chk("masked irq", 32'h0, {31'h0, irq});
    wr(`OFS_FLAGS, 32'h00200000);
    wr(`OFS_FLAGS, 32'h0);
    wr(`OFS_FLAGS, 32'hffffffff, 4'h7);
    rchk("w1c", `OFS_FLAGS, 32'h80000000);
    wr(`OFS_FLAGS, 32'hffffffff);
    wr(`OFS_INHIBIT, 32'hffffffff);
    rchk("inhibit", `OFS_INHIBIT, `FLAG_MASK);
    wr(`OFS_INHIBIT, 32'h80200000);
    repeat (2) core.fire(ev_of(0));
    repeat (2) core.fire(ev_of(10));
    rchk("inhibited", `OFS_FLAGS, 32'h00000100);
    chk("irq", 32'h1, {31'h0, irq});
    wr(`OFS_INHIBIT, 32'h0);
    $display("Test repeat done");
    // Only the first error is captured until valid is cleared
    wr(`OFS_FLAGS, 32'hffffffff);
    wr(`OFS_CAPSTAT, 32'h1);
    cap <= '{5'h05, 1'b1};
    core.fire(ev_of(4));
    cap <= '{5'h09, 1'b0};
    core.fire(ev_of(5));
    rchk("capture", `OFS_CAPSTAT, 32'h0000004b);
    wr(`OFS_CAPSTAT, 32'h1);
    core.fire(ev_of(6));
    rchk("recapture", `OFS_CAPSTAT, 32'h00000013);
    $display("Test capture done");
    // Threshold counts consecutive retry completions only
    wr(`OFS_FLAGS, 32'hffffffff);
    core.fire(ev_of(14));
    core.fire(ev_of(15));
    core.fire(ev_of(14));
    rchk("no threshold", `OFS_FLAGS, 32'h0);
    core.fire(ev_of(14));
    // The error answer stands for the one cycle after the threshold
    @(posedge ref_clk) chk("crs pulse", 32'h1, {31'h0, crs_resp});
    rchk("threshold", `OFS_FLAGS, 32'h00008000);
    $display("Test retry done");
    // Answered request stays quiet; unanswered one times out
    core.np_req(5, 1'b1);
    repeat (TMO + 4) @(posedge ref_clk);
    rchk("answered", `OFS_FLAGS, 32'h00008000);
    core.np_req(0, 1'b0);
    for (t = 0; t < 4 * TMO && to_resp !== 1'b1; t++) @(posedge ref_clk);
    chk("timeout pulse", 32'h1, {31'h0, to_resp});
    rchk("timeout flag", `OFS_FLAGS, 32'h00808000);
    // A low enable freezes the block, so a strobe in that time is lost
    @(posedge ref_clk) ce <= 1'b0;
    core.fire(ev_of(0));
    ce <= 1'b1;
    rchk("frozen", `OFS_FLAGS, 32'h00808000);
    // Software recovers from the fatal timeout by reset
    resetn <= 1'b0;
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    rchk("after reset", `OFS_FLAGS, 32'h0);
    $display("Test timeout done");
    end_of_test();
  end
endmodule // tb
